// [verilog/hsp_pkg.sv]
// Constants, types and helpers shared by the stream prefetcher
package hsp_pkg;
	localparam int ADDR_W = 32;
	localparam int LINE_OFF_W = 6;
	localparam int LINE_BYTES = 64;
	localparam int PAGE_OFF_W = 12;
	localparam int PAGE_W = ADDR_W - PAGE_OFF_W;
	localparam int LINE_IDX_W = PAGE_OFF_W - LINE_OFF_W;
	localparam int LINE_ADDR_W = ADDR_W - LINE_OFF_W;
	localparam int DIST_BYTES = 256;
	localparam int DIST_LINES = (DIST_BYTES + LINE_BYTES - 1) / LINE_BYTES;
	localparam logic [LINE_IDX_W:0] DIST_L = (LINE_IDX_W + 1)'(DIST_LINES);
	localparam logic [LINE_IDX_W:0] LAST_LINE = 7'h3f;
	localparam int PRI_STREAMS = 8;
	localparam int ALT_ASC = 12;
	localparam int ALT_DESC = 4;
	localparam logic [1:0] SW_LINES_PRI = 2'h2;
	localparam logic [1:0] SW_LINES_ALT = 2'h1;
	localparam logic [1:0] LVL_L1 = 2'h1;
	localparam logic [1:0] LVL_L2 = 2'h2;
	localparam logic [1:0] LVL_L3 = 2'h3;
	localparam logic [1:0] uncacheable_type = 2'h1;
	localparam logic [1:0] write_combining_type = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic store;
		logic [1:0] mtype;
	} hsp_access_type;

	typedef struct packed {
		logic [LINE_ADDR_W-1:0] line_addr;
		logic read_for_ownership_request;
		logic [1:0] level;
	} hsp_req_type;

	typedef struct packed {
		logic valid;
		logic trained;
		logic up;
		logic store;
		logic [PAGE_W-1:0] page;
		logic [LINE_IDX_W-1:0] last;
		logic [LINE_IDX_W-1:0] next;
	} hsp_entry_type;

	typedef enum logic [1:0] {
		SW_IDLE = 2'b01,
		SW_BUSY = 2'b10
	} hsp_sw_state_type;

	function automatic logic is_cacheable(input logic [1:0] mt);
		return mt != uncacheable_type && mt != write_combining_type;
	endfunction

	function automatic logic [PAGE_W-1:0] page_of(
		input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:PAGE_OFF_W];
	endfunction

	function automatic logic [LINE_IDX_W-1:0] line_of(
		input logic [ADDR_W-1:0] a);
		return a[PAGE_OFF_W-1:LINE_OFF_W];
	endfunction

	// Target clamps inside the page so no request leaves it
	function automatic logic [LINE_IDX_W:0] target_of(
		input hsp_entry_type e);
		logic [LINE_IDX_W:0] s;
		s = {1'b0, e.last} + DIST_L;
		if (e.up) begin
			return (s > LAST_LINE) ? LAST_LINE : s;
		end
		return ({1'b0, e.last} < DIST_L) ? '0 : {1'b0, e.last} - DIST_L;
	endfunction

	function automatic logic pending(input hsp_entry_type e);
		logic [LINE_IDX_W:0] t;
		t = target_of(e);
		if (!(e.valid && e.trained)) begin
			return 1'b0;
		end
		return e.up ? ({1'b0, e.next} < t) : ({1'b0, e.next} > t);
	endfunction
endpackage

// [verilog/hsp_lru.sv]
// Recency order of stream entries and least recent victim
`timescale 1ns/100ps
module hsp_lru #(
	parameter int N = 16,
	parameter int W = 4
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic touch_i,
	input wire logic [W-1:0] touch_idx_i,
	input wire logic [W:0] limit_i,
	output logic [W-1:0] victim_o
);
	logic [W-1:0] age_reg [N];
	logic [W-1:0] age_next [N];
	logic [W-1:0] victim_reg;
	logic [W-1:0] victim_next;
	logic [W-1:0] best;

	// Ages stay a permutation, so the oldest of any subset is its LRU
	always_comb begin
		age_next = age_reg;
		best = '0;
		victim_next = '0;
		if (touch_i) begin
			for (int j = 0; j < N; j++) begin
				if (age_reg[j] < age_reg[touch_idx_i]) begin
					age_next[j] = age_reg[j] + 1'b1;
				end
			end
			age_next[touch_idx_i] = '0;
		end
		// Victim from updated ages, never stale after a touch
		for (int j = 0; j < N; j++) begin
			if ((W + 1)'(j) < limit_i && age_next[j] >= best) begin
				best = age_next[j];
				victim_next = W'(j);
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int j = 0; j < N; j++) begin
				age_reg[j] <= W'(j);
			end
			victim_reg <= '0;
		end else if (ce_i) begin
			age_reg <= age_next;
			victim_reg <= victim_next;
		end
	end

	assign victim_o = victim_reg;
endmodule

// [verilog/hsp_prefetch.sv]
// Hardware stream prefetcher: trains on core accesses, issues lines
// Behaviour
// - Prefetching starts by itself from observed accesses alone.
// - Ascending and descending unit-line streams are both followed.
// - Each stream runs up to 256 bytes ahead of its last access.
// - At most one stream is tracked in any aligned 4K page.
// - Up to 8 streams from different 4K pages are active at once, 16 in alternative mode.
// - No request leaves the 4K page of its stream.
// - Fills go to the second or third level, never the first.
// - Uncacheable and write-combining accesses never prefetch.
// - Store streams ask for ownership, load streams for plain reads.
// - Alternative mode fills L2 with 12 ascending, 4 descending.
// - A software prefetch fetches two lines, one in alternative mode.
`timescale 1ns/100ps
module hsp_prefetch #(
	parameter int NUM_ENT = hsp_pkg::ALT_ASC + hsp_pkg::ALT_DESC,
	parameter bit HAS_L3 = 1'b1
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic alt_mode_i,
	input wire logic acc_valid_i,
	input wire hsp_pkg::hsp_access_type acc_i,
	input wire logic sw_valid_i,
	input wire hsp_pkg::hsp_access_type sw_i,
	output logic sw_ready_o,
	output logic req_valid_o,
	output hsp_pkg::hsp_req_type req_o,
	input wire logic req_ready_i
);
	import hsp_pkg::*;

	localparam int IW = $clog2(NUM_ENT);

	hsp_entry_type ent_reg [NUM_ENT];
	hsp_entry_type ent_next [NUM_ENT];
	hsp_entry_type e;
	hsp_entry_type pe;
	hsp_sw_state_type sw_state_reg;
	hsp_sw_state_type sw_state_next;
	logic [LINE_ADDR_W-1:0] sw_line_reg;
	logic [LINE_ADDR_W-1:0] sw_line_next;
	logic [1:0] sw_left_reg;
	logic [1:0] sw_left_next;
	logic req_valid_reg;
	logic req_valid_next;
	hsp_req_type req_reg;
	hsp_req_type req_next;
	logic [IW:0] limit;
	logic [IW:0] asc_cnt;
	logic [IW:0] desc_cnt;
	logic hit;
	logic free;
	logic pick_ok;
	logic dup;
	logic [IW-1:0] hit_idx;
	logic [IW-1:0] free_idx;
	logic [IW-1:0] pick_idx;
	logic [IW-1:0] slot;
	logic [IW-1:0] victim;
	logic out_free;
	logic sw_issue;
	logic st_issue;
	logic touch;
	logic step_up;
	logic step_dn;
	logic fresh;
	logic quota;
	logic [1:0] level;
	logic [LINE_IDX_W-1:0] ln;
	logic [LINE_IDX_W-1:0] nl;

	// Lookup, free slot, issue pick and per-direction counts
	always_comb begin
		limit = alt_mode_i ? (IW + 1)'(NUM_ENT) :
			(IW + 1)'(PRI_STREAMS);
		hit = 1'b0;
		hit_idx = '0;
		free = 1'b0;
		free_idx = '0;
		pick_ok = 1'b0;
		pick_idx = '0;
		asc_cnt = '0;
		desc_cnt = '0;
		dup = 1'b0;
		for (int i = NUM_ENT - 1; i >= 0; i--) begin
			if ((IW + 1)'(i) < limit) begin
				if (ent_reg[i].valid &&
					ent_reg[i].page == page_of(acc_i.addr)) begin
					hit = 1'b1;
					hit_idx = IW'(i);
				end
				if (!ent_reg[i].valid) begin
					free = 1'b1;
					free_idx = IW'(i);
				end
				if (pending(ent_reg[i])) begin
					pick_ok = 1'b1;
					pick_idx = IW'(i);
				end
			end
			if (ent_reg[i].valid && ent_reg[i].trained) begin
				if (ent_reg[i].up) begin
					asc_cnt = asc_cnt + 1'b1;
				end else begin
					desc_cnt = desc_cnt + 1'b1;
				end
			end
			for (int k = 0; k < i; k++) begin
				if (ent_reg[i].valid && ent_reg[k].valid &&
					ent_reg[i].page == ent_reg[k].page) begin
					dup = 1'b1;
				end
			end
		end
	end

	// Software prefetch has priority; it is short and explicit
	assign out_free = !req_valid_reg || req_ready_i;
	assign pe = ent_reg[pick_idx];
	assign sw_issue = (sw_state_reg == SW_BUSY) && out_free;
	assign st_issue = (sw_state_reg != SW_BUSY) && pick_ok && out_free;
	assign level = (alt_mode_i || !HAS_L3) ? LVL_L2 : LVL_L3;

	// Stream table update
	always_comb begin
		ent_next = ent_reg;
		e = ent_reg[hit_idx];
		nl = pe.up ? pe.next + 1'b1 : pe.next - 1'b1;
		ln = line_of(acc_i.addr);
		step_up = 1'b0;
		step_dn = 1'b0;
		fresh = 1'b0;
		quota = 1'b0;
		touch = 1'b0;
		slot = free ? free_idx : victim;
		if (st_issue) begin
			ent_next[pick_idx].next = nl;
		end
		if (acc_valid_i) begin
			if (!is_cacheable(acc_i.mtype)) begin
				if (hit) begin
					ent_next[hit_idx].valid = 1'b0;
				end
			end else if (hit) begin
				e = ent_reg[hit_idx];
				touch = 1'b1;
				step_up = {1'b0, ln} == {1'b0, e.last} + 1'b1;
				step_dn = {1'b0, ln} + 1'b1 == {1'b0, e.last};
				if (step_up || step_dn) begin
					fresh = !e.trained || e.up != step_up;
					quota = !alt_mode_i || (step_up ?
						asc_cnt < (IW + 1)'(ALT_ASC) :
						desc_cnt < (IW + 1)'(ALT_DESC));
					if (fresh) begin
						ent_next[hit_idx].trained = quota;
						ent_next[hit_idx].up = step_up;
					end
					// Never prefetch lines already behind the access
					if (fresh || (step_up ? ent_next[hit_idx].next < ln :
						ent_next[hit_idx].next > ln)) begin
						ent_next[hit_idx].next = ln;
					end
				end else if (ln != e.last) begin
					ent_next[hit_idx].trained = 1'b0;
				end
				ent_next[hit_idx].last = ln;
				ent_next[hit_idx].store = acc_i.store;
			end else begin
				touch = 1'b1;
				// One entry per page: allocate only on a page miss
				ent_next[slot] = '{valid: 1'b1, trained: 1'b0,
					up: 1'b1, store: acc_i.store,
					page: page_of(acc_i.addr), last: ln, next: ln};
			end
		end
	end

	// Request register and software prefetch sequencer
	always_comb begin
		req_valid_next = req_valid_reg && !req_ready_i;
		req_next = req_reg;
		sw_state_next = sw_state_reg;
		sw_line_next = sw_line_reg;
		sw_left_next = sw_left_reg;
		if (sw_issue) begin
			req_valid_next = 1'b1;
			req_next = '{line_addr: sw_line_reg,
				read_for_ownership_request: 1'b0, level: level};
		end else if (st_issue) begin
			req_valid_next = 1'b1;
			req_next = '{line_addr: {pe.page, nl},
				read_for_ownership_request: pe.store,
				level: level};
		end
		unique case (sw_state_reg)
			SW_IDLE: begin
				if (sw_valid_i && is_cacheable(sw_i.mtype)) begin
					sw_state_next = SW_BUSY;
					// Aligned pair stays inside the page
					if (alt_mode_i) begin
						sw_line_next = sw_i.addr[ADDR_W-1:LINE_OFF_W];
						sw_left_next = SW_LINES_ALT - 1'b1;
					end else begin
						sw_line_next = {sw_i.addr[ADDR_W-1:LINE_OFF_W+1], 1'b0};
						sw_left_next = SW_LINES_PRI - 1'b1;
					end
				end
			end
			SW_BUSY: begin
				if (out_free) begin
					sw_line_next = sw_line_reg + 1'b1;
					sw_left_next = sw_left_reg - 1'b1;
					if (sw_left_reg == 2'h0) begin
						sw_state_next = SW_IDLE;
					end
				end
			end
			default: begin
				sw_state_next = SW_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < NUM_ENT; i++) begin
				ent_reg[i] <= '0;
			end
			sw_state_reg <= SW_IDLE;
			sw_line_reg <= '0;
			sw_left_reg <= 2'h0;
			req_valid_reg <= 1'b0;
			req_reg <= '0;
		end else if (ce_i) begin
			ent_reg <= ent_next;
			sw_state_reg <= sw_state_next;
			sw_line_reg <= sw_line_next;
			sw_left_reg <= sw_left_next;
			req_valid_reg <= req_valid_next;
			req_reg <= req_next;
		end
	end

	hsp_lru #(
		.N(NUM_ENT),
		.W(IW)
	) u_lru (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.touch_i(touch),
		.touch_idx_i(hit ? hit_idx : slot),
		.limit_i(limit),
		.victim_o(victim)
	);

	assign sw_ready_o = sw_state_reg[0];
	assign req_valid_o = req_valid_reg;
	assign req_o = req_reg;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	a_auto_issue: assert property (ce_i && st_issue |=> req_valid_o)
		else $error("pending stream did not issue");
	a_dir_follow: assert property (ce_i && st_issue && !acc_valid_i
		|=> req_o.line_addr[LINE_IDX_W-1:0] ==
		ent_reg[$past(pick_idx)].next)
		else $error("issued line not along stream direction");
	generate
		for (genvar g = 0; g < NUM_ENT; g++) begin : g_ahead
			a_stay_ahead: assert property (ent_reg[g].trained &&
				ent_reg[g].up |-> {1'b0, ent_reg[g].next} <=
				{1'b0, ent_reg[g].last} + DIST_L)
				else $error("stream runs too far ahead");
		end
	endgenerate
	a_one_per_page: assert property (!dup)
		else $error("two entries track the same page");
	a_stream_limit: assert property (!alt_mode_i && !$past(alt_mode_i)
		&& ce_i && st_issue |-> pick_idx < IW'(PRI_STREAMS))
		else $error("too many streams in primary mode");
	a_page_bound: assert property (st_issue |-> (pe.up ?
		pe.next != LAST_LINE[LINE_IDX_W-1:0] : pe.next != '0))
		else $error("request would cross the page");
	a_no_l1_fill: assert property (req_valid_o |->
		req_o.level != LVL_L1 && (!alt_mode_i || req_o.level == LVL_L2))
		else $error("bad fill level");
	a_uncached_drop: assert property (ce_i && acc_valid_i && hit &&
		!is_cacheable(acc_i.mtype) |=> !ent_reg[$past(hit_idx)].valid)
		else $error("uncacheable page still tracked");
	a_ownership_kind: assert property (ce_i && st_issue |=>
		req_o.read_for_ownership_request == $past(pe.store))
		else $error("wrong request kind");
	a_alt_quota: assert property (alt_mode_i && $past(alt_mode_i) &&
		ce_i && acc_valid_i && fresh |=> asc_cnt <= (IW + 1)'(ALT_ASC) &&
		desc_cnt <= (IW + 1)'(ALT_DESC))
		else $error("direction quota exceeded");
	a_sw_lines: assert property (ce_i && sw_issue && sw_left_reg != 0
		|=> sw_state_reg == SW_BUSY)
		else $error("software prefetch ended early");
	a_lru_victim: assert property (ce_i && acc_valid_i && !hit && !free
		&& is_cacheable(acc_i.mtype) |=> ent_reg[$past(victim)].page ==
		page_of($past(acc_i.addr)))
		else $error("victim not replaced");
endmodule

// [dv/hsp_sink.sv]
// Cache request path model: random stalls, records accepted lines
`timescale 1ns/100ps
module hsp_sink (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic stall_i,
	input wire logic req_valid_i,
	input wire hsp_pkg::hsp_req_type req_i,
	output logic req_ready_o,
	output logic hold_err_o
);
	import hsp_pkg::*;
	hsp_req_type got_q[$];
	hsp_req_type held;
	logic waiting;
	// Stalls come from the bench so one seed rules all randomness
	assign req_ready_o = !stall_i;
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			waiting <= 1'b0;
			hold_err_o <= 1'b0;
		end else if (ce_i && req_valid_i) begin
			if (waiting && req_i !== held) begin
				hold_err_o <= 1'b1;
			end
			if (req_ready_o) begin
				got_q.push_back(req_i);
			end
			waiting <= !req_ready_o;
			held <= req_i;
		end else if (ce_i && waiting) begin
			hold_err_o <= 1'b1;
		end
	end
endmodule

// [dv/tb.sv]
// Self-checking bench for the stream prefetcher
`timescale 1ns/100ps
module tb;
	import hsp_pkg::*;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic alt_mode_i = 1'b0;
	logic acc_valid_i = 1'b0;
	logic sw_valid_i = 1'b0;
	logic stall = 1'b0;
	hsp_access_type acc_i = '0;
	hsp_access_type sw_i = '0;
	logic sw_ready_o;
	logic req_valid_o;
	logic req_ready_i;
	logic hold_err;
	hsp_req_type req_o;
	int mismatches = 0;
	int checked = 0;
	int i;
	int l0;
	bit up;
	bit st;

	always #25 clock_i = ~clock_i;

	hsp_prefetch hsp_prefetch_inst (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.alt_mode_i(alt_mode_i), .acc_valid_i(acc_valid_i),
		.acc_i(acc_i), .sw_valid_i(sw_valid_i), .sw_i(sw_i),
		.sw_ready_o(sw_ready_o), .req_valid_o(req_valid_o),
		.req_o(req_o), .req_ready_i(req_ready_i)
	);
	hsp_sink hsp_sink_inst (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.stall_i(stall),
		.req_valid_i(req_valid_o), .req_i(req_o),
		.req_ready_o(req_ready_i), .hold_err_o(hold_err)
	);

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic tick();
		@(posedge clock_i);
		#5;
	endtask

	task automatic do_reset();
		reset_n_i = 1'b0;
		repeat (6) tick();
		reset_n_i = 1'b1;
		chk("sw_ready", 32'h1, sw_ready_o);
		chk("req_valid", 32'h0, req_valid_o);
	endtask

	// Waits for n lines under random stalls, then idles to catch extras
	task automatic drain(input int n);
		int c;
		for (c = 0; c < 60 && hsp_sink_inst.got_q.size() < n; c++) begin
			stall = ($urandom_range(3) == 0);
			ce_i = ($urandom_range(4) != 0);
			tick();
		end
		stall = 1'b0;
		ce_i = 1'b1;
		if (hsp_sink_inst.got_q.size() < n) begin
			mismatches++;
			$display("[ERR] wait expected %0d seen %0d", n,
				hsp_sink_inst.got_q.size());
			wrap_up();
		end
		repeat (8) tick();
		chk("count", n, hsp_sink_inst.got_q.size());
		chk("hold", 32'h0, hold_err);
	endtask

	function automatic int n_exp(input int last, input bit up);
		if (up) begin
			return (63 - last < 4) ? 63 - last : 4;
		end
		return (last < 4) ? last : 4;
	endfunction

	task automatic acc1(input logic [31:0] a, input logic s,
		input logic [1:0] mt);
		acc_valid_i = 1'b1;
		acc_i = '{addr: a, store: s, mtype: mt};
		tick();
		acc_valid_i = 1'b0;
	endtask

	task automatic stream(input logic [19:0] pg, input int l0,
		input bit up, input logic s, input logic [1:0] mt, input bit on);
		int last;
		int n;
		hsp_req_type r;
		logic [1:0] lvl;
		last = up ? l0 + 1 : l0 - 1;
		n = on ? n_exp(last, up) : 0;
		lvl = alt_mode_i ? LVL_L2 : LVL_L3;
		acc_valid_i = 1'b1;
		acc_i = '{addr: {pg, 6'(l0), 6'h00}, store: s, mtype: mt};
		tick();
		acc1({pg, 6'(last), 6'h00}, s, mt);
		drain(n);
		foreach (hsp_sink_inst.got_q[k]) begin
			r = hsp_sink_inst.got_q[k];
			chk("line", {pg, 6'(up ? last + k + 1 : last - k - 1)},
				r.line_addr);
			chk("ownership", s, r.read_for_ownership_request);
			chk("level", lvl, r.level);
		end
		hsp_sink_inst.got_q.delete();
	endtask

	// One step along a trained stream adds exactly one line
	task automatic cont(input logic [19:0] pg, input int l, input bit on);
		acc1({pg, 6'(l), 6'h00}, 1'b0, 2'h0);
		drain(on ? 1 : 0);
		if (on) begin
			chk("cont line", {pg, 6'(l + 4)},
				hsp_sink_inst.got_q[0].line_addr);
		end
		hsp_sink_inst.got_q.delete();
	endtask

	task automatic swp(input logic [31:0] a);
		int n;
		n = alt_mode_i ? 1 : 2;
		chk("sw_ready", 32'h1, sw_ready_o);
		sw_valid_i = 1'b1;
		sw_i = '{addr: a, store: 1'b0, mtype: 2'h0};
		tick();
		sw_valid_i = 1'b0;
		chk("sw_ready", 32'h0, sw_ready_o);
		drain(n);
		foreach (hsp_sink_inst.got_q[k]) begin
			chk("sw line", alt_mode_i ? a[31:6] : {a[31:7], 1'(k)},
				hsp_sink_inst.got_q[k].line_addr);
			chk("sw level", alt_mode_i ? LVL_L2 : LVL_L3,
				hsp_sink_inst.got_q[k].level);
		end
		hsp_sink_inst.got_q.delete();
	endtask

	initial begin
		void'($urandom(32'hd2938683));
		do_reset();
		stream(20'h00001, 0, 1, 1'b0, 2'h0, 1);
		stream(20'h00002, 4, 0, 1'b1, 2'h0, 1);
		stream(20'h00003, 62, 1, 1'b0, 2'h0, 1);
		stream(20'h00004, 10, 1, 1'b0, uncacheable_type, 0);
		stream(20'h00005, 10, 0, 1'b1, write_combining_type, 0);
		// Uncacheable hit must drop the trained page-1 stream
		acc1(32'h000010c0, 1'b0, uncacheable_type);
		cont(20'h00001, 2, 0);
		swp(32'h00005040);
		for (i = 0; i < 6; i++) begin
			l0 = $urandom_range(62, 1);
			up = $urandom_range(1);
			st = $urandom_range(1);
			stream(20'(i + 256), l0, up, st, {st, st}, 1);
		end
		// Fresh state so the recency order is known
		do_reset();
		for (i = 0; i < 8; i++) begin
			stream(20'(i + 16), 8, 1, 1'b0, 2'h0, 1);
		end
		for (i = 0; i < 8; i++) begin
			cont(20'(i + 16), 10, 1);
		end
		stream(20'h00018, 8, 1, 1'b1, 2'h0, 1);
		cont(20'h00011, 11, 1);
		cont(20'h00010, 11, 0);
		do_reset();
		alt_mode_i = 1'b1;
		for (i = 0; i < 5; i++) begin
			stream(20'(i + 32), 20, 0, 1'b0, 2'h0, i < 4);
		end
		swp(32'h00006080);
		wrap_up();
	end
endmodule
